// ==== rtl/drive_homing_io_config.v ====
// Notes on behaviour
// - signed 32-bit preset, used by method 35 immediately
// - zero search limit disables distance monitoring
// - nonzero limit cancels homing on overrun
// - policy 0 enables on enable-input rising edge
// - policy 1 enables while enable input active
// - policy 2 enables automatically
// - policy change applies at next enable
// - output bits drive digital outputs in order
// - pin-1 input codes select input role
// - pin-1 codes 101-103 select output role
// - fault reset and enable only local mode
// - pin function writable only when disabled
// - pin function applies after next power-on
`timescale 1ns/1ps
`default_nettype none
`include "drive_homing_io_map.vh"
module drive_homing_io_config #(
    parameter OUT_WIDTH = 16
) (
    // clock and reset
    input  wire                 sys_clk,
    input  wire                 sys_rst,
    // parameter access
    input  wire                 par_wr,
    input  wire                 par_rd,
    input  wire [15:0]          par_addr,
    input  wire [31:0]          par_wdata,
    output reg  [31:0]          par_rdata_r,
    output reg                  par_ack_r,
    output reg                  par_err_r,
    // drive state
    input  wire                 local_mode,
    input  wire                 disable_req,
    input  wire                 drive_fault,
    input  wire                 drive_ready,
    input  wire [7:0]           homing_method,
    input  wire                 move_start,
    input  wire                 search_active,
    input  wire                 step_pulse,
    input  wire                 switch_seen,
    // local pin 1
    input  wire                 local_io_pin1_in,
    output reg                  local_io_pin1_out_r,
    output reg                  local_io_pin1_oe_r,
    // results
    output reg                  power_stage_en_r,
    output reg                  fault_reset_r,
    output reg                  halt_r,
    output reg                  jog_positive_r,
    output reg                  jog_fast_r,
    output reg                  home_switch_r,
    output reg                  positive_travel_stop_r,
    output reg  [OUT_WIDTH-1:0] digital_out_r,
    output reg  [31:0]          home_position_r,
    output reg                  home_position_load_r,
    output reg                  search_cancel_r
);
    reg [15:0] power_on_enable_policy_r;
    reg [15:0] pin1_function_select_r = `RST_PIN1_FUNCTION_SELECT;
    reg [15:0] direct_output_bits_r;
    reg [31:0] homing_preset_position_r;
    reg [31:0] overtravel_search_limit_r;
    reg [15:0] active_policy_r;
    reg [15:0] pin1_active_fn_r;
    reg        strap_done_r;
    reg        enable_in_d_r;
    reg [31:0] rdata_nxt;
    reg        hit;
    wire       cancel;
    wire       fn_in;
    wire       enable_in;
    wire       enable_rise;
    wire       pin1_wr_ok;

    function is_valid_fn;
        input [15:0] c;
        begin
            case (c)
                `FN_IN_FREE, `FN_IN_FAULT_RESET, `FN_IN_ENABLE, `FN_IN_HALT,
                `FN_IN_JOG_POS, `FN_IN_JOG_FAST, `FN_IN_HOME_SWITCH,
                `FN_IN_POS_TRAVEL_STOP, `FN_OUT_FREE, `FN_OUT_NO_FAULT,
                `FN_OUT_READY: is_valid_fn = 1'b1;
                default: is_valid_fn = 1'b0;
            endcase
        end
    endfunction

    function role_on;
        input [15:0] fn;
        input [15:0] code;
        input        pin;
        begin
            role_on = (fn == code) && pin;
        end
    endfunction

    assign fn_in       = pin1_active_fn_r < `FN_OUT_FREE;
    assign enable_in   = role_on(pin1_active_fn_r, `FN_IN_ENABLE,
                                 local_io_pin1_in) && local_mode;
    assign enable_rise = enable_in && !enable_in_d_r;
    assign pin1_wr_ok  = par_wr && par_addr == `ADDR_PIN1_FUNCTION_SELECT &&
                         !power_stage_en_r &&
                         is_valid_fn(par_wdata[15:0]);

    search_monitor u_search (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .move_start    (move_start),
        .search_active (search_active),
        .step_pulse    (step_pulse),
        .switch_seen   (switch_seen),
        .limit_value   (overtravel_search_limit_r),
        .cancel_r      (cancel)
    );

    always @* begin
        hit = 1'b1;
        case (par_addr)
            `ADDR_POWER_ON_ENABLE_POLICY:
                rdata_nxt = {16'h0000, power_on_enable_policy_r};
            `ADDR_PIN1_FUNCTION_SELECT:
                rdata_nxt = {16'h0000, pin1_function_select_r};
            `ADDR_DIRECT_OUTPUT_BITS:
                rdata_nxt = {16'h0000, direct_output_bits_r};
            `ADDR_HOMING_PRESET_POSITION:
                rdata_nxt = homing_preset_position_r;
            `ADDR_OVERTRAVEL_SEARCH_LIMIT:
                rdata_nxt = overtravel_search_limit_r;
            default: begin
                rdata_nxt = 32'h0000_0000;
                hit = 1'b0;
            end
        endcase
    end

    // parameter access
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_on_enable_policy_r  <= `RST_POWER_ON_ENABLE_POLICY;
            direct_output_bits_r      <= `RST_DIRECT_OUTPUT_BITS;
            homing_preset_position_r  <= `RST_HOMING_PRESET_POSITION;
            overtravel_search_limit_r <= `RST_OVERTRAVEL_SEARCH_LIMIT;
            par_rdata_r               <= 32'h0000_0000;
            par_ack_r                 <= 1'b0;
            par_err_r                 <= 1'b0;
        end else begin
            par_ack_r   <= par_wr || par_rd;
            par_err_r   <= 1'b0;
            par_rdata_r <= par_rd ? rdata_nxt : 32'h0000_0000;
            if ((par_wr || par_rd) && !hit)
                par_err_r <= 1'b1;
            if (par_wr && hit) begin
                case (par_addr)
                    `ADDR_POWER_ON_ENABLE_POLICY:
                        if (par_wdata[15:0] <= `POLICY_AUTO)
                            power_on_enable_policy_r <= par_wdata[15:0];
                        else
                            par_err_r <= 1'b1;
                    `ADDR_PIN1_FUNCTION_SELECT:
                        if (!pin1_wr_ok)
                            par_err_r <= 1'b1;
                    `ADDR_DIRECT_OUTPUT_BITS:
                        direct_output_bits_r <= par_wdata[15:0];
                    `ADDR_HOMING_PRESET_POSITION:
                        homing_preset_position_r <= par_wdata;
                    `ADDR_OVERTRAVEL_SEARCH_LIMIT:
                        if (!par_wdata[31])
                            overtravel_search_limit_r <= par_wdata;
                        else
                            par_err_r <= 1'b1;
                    default: par_err_r <= 1'b1;
                endcase
            end
        end
    end

    // kept through sys_rst so a new pin function acts after power-on
    always @(posedge sys_clk) begin
        if (pin1_wr_ok && !sys_rst)
            pin1_function_select_r <= par_wdata[15:0];
    end

    // power stage enable and pin function
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            active_policy_r      <= `RST_POWER_ON_ENABLE_POLICY;
            pin1_active_fn_r     <= `RST_PIN1_FUNCTION_SELECT;
            strap_done_r         <= 1'b0;
            enable_in_d_r        <= 1'b0;
            power_stage_en_r     <= 1'b0;
        end else begin
            enable_in_d_r <= enable_in;
            // pin function captured once after power-on
            if (!strap_done_r) begin
                pin1_active_fn_r <= pin1_function_select_r;
                strap_done_r     <= 1'b1;
            end
            if (power_stage_en_r) begin
                if (disable_req || drive_fault ||
                    (active_policy_r == `POLICY_LEVEL && !enable_in))
                    power_stage_en_r <= 1'b0;
            end else if (strap_done_r && !drive_fault && !disable_req) begin
                case (power_on_enable_policy_r)
                    `POLICY_EDGE: if (enable_rise) begin
                        power_stage_en_r <= 1'b1;
                        active_policy_r  <= power_on_enable_policy_r;
                    end
                    `POLICY_LEVEL: if (enable_in) begin
                        power_stage_en_r <= 1'b1;
                        active_policy_r  <= power_on_enable_policy_r;
                    end
                    `POLICY_AUTO: begin
                        power_stage_en_r <= 1'b1;
                        active_policy_r  <= power_on_enable_policy_r;
                    end
                    default: power_stage_en_r <= 1'b0;
                endcase
            end
        end
    end

    // role outputs and digital outputs
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_reset_r          <= 1'b0;
            halt_r                 <= 1'b0;
            jog_positive_r         <= 1'b0;
            jog_fast_r             <= 1'b0;
            home_switch_r          <= 1'b0;
            positive_travel_stop_r <= 1'b0;
            local_io_pin1_out_r    <= 1'b0;
            local_io_pin1_oe_r     <= 1'b0;
            digital_out_r          <= {OUT_WIDTH{1'b0}};
            home_position_r        <= 32'h0000_0000;
            home_position_load_r   <= 1'b0;
            search_cancel_r        <= 1'b0;
        end else begin
            fault_reset_r <= role_on(pin1_active_fn_r, `FN_IN_FAULT_RESET,
                                     local_io_pin1_in) && local_mode;
            halt_r <= role_on(pin1_active_fn_r, `FN_IN_HALT,
                              local_io_pin1_in);
            jog_positive_r <= role_on(pin1_active_fn_r, `FN_IN_JOG_POS,
                                      local_io_pin1_in);
            jog_fast_r <= role_on(pin1_active_fn_r, `FN_IN_JOG_FAST,
                                  local_io_pin1_in);
            home_switch_r <= role_on(pin1_active_fn_r, `FN_IN_HOME_SWITCH,
                                     local_io_pin1_in);
            positive_travel_stop_r <= role_on(pin1_active_fn_r,
                `FN_IN_POS_TRAVEL_STOP, local_io_pin1_in);
            local_io_pin1_oe_r <= !fn_in;
            case (pin1_active_fn_r)
                `FN_OUT_FREE:
                    local_io_pin1_out_r <= direct_output_bits_r[0];
                `FN_OUT_NO_FAULT:
                    local_io_pin1_out_r <= !drive_fault;
                `FN_OUT_READY:
                    local_io_pin1_out_r <= drive_ready;
                default: local_io_pin1_out_r <= 1'b0;
            endcase
            digital_out_r <= direct_output_bits_r[OUT_WIDTH-1:0];
            home_position_r <= homing_preset_position_r;
            home_position_load_r <= move_start &&
                (homing_method == `HOMING_METHOD_PRESET);
            search_cancel_r <= cancel;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/drive_homing_io_map.vh ====
`ifndef DRIVE_HOMING_IO_MAP_VH
`define DRIVE_HOMING_IO_MAP_VH
// parameter addresses
`define ADDR_POWER_ON_ENABLE_POLICY  16'h050C
`define ADDR_PIN1_FUNCTION_SELECT    16'h0722
`define ADDR_DIRECT_OUTPUT_BITS      16'h0822
`define ADDR_HOMING_PRESET_POSITION  16'h1B2C
`define ADDR_OVERTRAVEL_SEARCH_LIMIT 16'h281A
// reset values and maximum search limit
`define RST_POWER_ON_ENABLE_POLICY   16'h0000
`define RST_PIN1_FUNCTION_SELECT     16'h0001
`define RST_DIRECT_OUTPUT_BITS       16'h0000
`define RST_HOMING_PRESET_POSITION   32'h0000_0000
`define RST_OVERTRAVEL_SEARCH_LIMIT  32'h0000_0000
`define MAX_OVERTRAVEL_SEARCH_LIMIT  32'h7FFF_FFFF
// enable policy codes
`define POLICY_EDGE                  16'h0000
`define POLICY_LEVEL                 16'h0001
`define POLICY_AUTO                  16'h0002
// pin 1 function codes
`define FN_IN_FREE                   16'h0001
`define FN_IN_FAULT_RESET            16'h0002
`define FN_IN_ENABLE                 16'h0003
`define FN_IN_HALT                   16'h0004
`define FN_IN_JOG_POS                16'h0009
`define FN_IN_JOG_FAST               16'h000A
`define FN_IN_HOME_SWITCH            16'h0014
`define FN_IN_POS_TRAVEL_STOP        16'h0015
`define FN_OUT_FREE                  16'h0065
`define FN_OUT_NO_FAULT              16'h0066
`define FN_OUT_READY                 16'h0067
// homing method using the preset position
`define HOMING_METHOD_PRESET         8'h23
`endif

// ==== rtl/search_monitor.v ====
`timescale 1ns/1ps
`default_nettype none
// tracks travelled distance after switch overtravel and cancels on overrun
module search_monitor (
    // clock and reset
    input  wire        sys_clk,
    input  wire        sys_rst,
    // control
    input  wire        move_start,
    input  wire        search_active,
    input  wire        step_pulse,
    input  wire        switch_seen,
    input  wire [31:0] limit_value,
    // result
    output reg         cancel_r
);
    reg [31:0] limit_r;
    reg [31:0] dist_r;

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            limit_r  <= 32'h0000_0000;
            dist_r   <= 32'h0000_0000;
            cancel_r <= 1'b0;
        end else begin
            // limit latched as the motor starts moving
            if (move_start) begin
                limit_r  <= limit_value;
                dist_r   <= 32'h0000_0000;
                cancel_r <= 1'b0;
            end else if (!search_active || switch_seen) begin
                dist_r <= 32'h0000_0000;
            end else if (step_pulse) begin
                dist_r <= dist_r + 32'h0000_0001;
                // zero limit: no monitoring
                if (limit_r != 32'h0000_0000 &&
                    dist_r + 32'h0000_0001 >= limit_r)
                    cancel_r <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/drive_homing_io_config_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "drive_homing_io_map.vh"
module drive_homing_io_config_sva #(
    parameter OUT_WIDTH = 16
) (
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 sys_rst,
    // parameter access
    input wire logic                 par_wr,
    input wire logic                 par_rd,
    input wire logic [15:0]          par_addr,
    input wire logic [31:0]          par_wdata,
    input wire logic [31:0]          par_rdata_r,
    input wire logic                 par_ack_r,
    input wire logic                 par_err_r,
    // drive state and results
    input wire logic                 disable_req,
    input wire logic                 drive_fault,
    input wire logic [7:0]           homing_method,
    input wire logic                 move_start,
    input wire logic                 power_stage_en_r,
    input wire logic [OUT_WIDTH-1:0] digital_out_r,
    input wire logic                 home_position_load_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_req;
        par_wr || par_rd;
    endsequence
    sequence s_wr_out;
        par_wr && par_addr == `ADDR_DIRECT_OUTPUT_BITS;
    endsequence
    chk_ack_follows: assert property (s_req |=> par_ack_r)
        else $error("request without ack");
    chk_ack_cause: assert property (par_ack_r |-> $past(par_wr || par_rd))
        else $error("ack without request");
    chk_rdata_idle: assert property (!par_ack_r |-> par_rdata_r == 32'h0)
        else $error("read data outside ack");
    chk_err_in_ack: assert property (par_err_r |-> par_ack_r)
        else $error("error without ack");
    chk_out_follow: assert property (
        s_wr_out |-> ##2 digital_out_r == $past(par_wdata[OUT_WIDTH-1:0], 2))
        else $error("outputs do not follow written bits");
    chk_preset_load: assert property (
        move_start && homing_method == `HOMING_METHOD_PRESET
        |=> home_position_load_r) else $error("preset not applied");
    chk_load_cause: assert property (
        home_position_load_r |-> $past(move_start &&
            homing_method == `HOMING_METHOD_PRESET))
        else $error("preset applied without move");
    chk_stage_off: assert property (
        disable_req || drive_fault |=> !power_stage_en_r)
        else $error("stage on while disabled");
    chk_pin_refused: assert property (
        par_wr && par_addr == `ADDR_PIN1_FUNCTION_SELECT && power_stage_en_r
        |=> par_err_r) else $error("pin write accepted while enabled");
    chk_policy_range: assert property (
        par_wr && par_addr == `ADDR_POWER_ON_ENABLE_POLICY
        && par_wdata[15:0] > 16'h0002 |=> par_err_r)
        else $error("bad policy accepted");
endmodule
bind drive_homing_io_config drive_homing_io_config_sva #(
    .OUT_WIDTH(OUT_WIDTH)) i_drive_homing_io_config_sva (.*);
`default_nettype wire

// ==== sim/drive_switch_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// pin 1 wire and travel step source
module drive_switch_model (
    input  wire logic       sys_clk,
    input  wire logic       pin_oe,
    input  wire logic       pin_out,
    input  wire logic       pin_ext,
    input  wire logic       go,
    input  wire logic [7:0] steps,
    output logic            pin_in,
    output logic            step_pulse
);
    logic [7:0] n = 8'h00;
    assign pin_in = pin_oe ? pin_out : pin_ext;
    initial step_pulse = 1'b0;
    always @(posedge sys_clk) begin
        if (go)
            n <= steps;
        else if (n != 8'h00)
            n <= n - 8'h01;
        step_pulse <= !go && n != 8'h00;
    end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "drive_homing_io_map.vh"
module tb;
    logic sys_clk = 0, sys_rst = 1, par_wr = 0, par_rd = 0, disable_req = 0;
    logic local_mode = 1, drive_fault = 0, drive_ready = 0, switch_seen = 0;
    logic move_start = 0, search_active = 0, pin_ext = 0, go = 0;
    logic [15:0] par_addr = 16'h0, digital_out_r;
    logic [31:0] par_wdata = 32'h0, par_rdata_r, home_position_r;
    logic [7:0] homing_method = 8'h23, steps = 8'h00;
    logic par_ack_r, par_err_r, local_io_pin1_out_r, local_io_pin1_oe_r;
    logic power_stage_en_r, fault_reset_r, halt_r, jog_positive_r, jog_fast_r;
    logic home_switch_r, positive_travel_stop_r, home_position_load_r;
    logic search_cancel_r, local_io_pin1_in, step_pulse;
    int n_mismatch = 0, n_tests = 0, i;
    always #2.5 sys_clk = ~sys_clk;
    drive_homing_io_config #(.OUT_WIDTH(16)) i_drive_homing_io_config (
        .sys_clk, .sys_rst, .par_wr, .par_rd, .par_addr, .par_wdata,
        .par_rdata_r, .par_ack_r, .par_err_r, .local_mode, .disable_req,
        .drive_fault, .drive_ready, .homing_method, .move_start,
        .search_active, .step_pulse, .switch_seen, .local_io_pin1_in,
        .local_io_pin1_out_r, .local_io_pin1_oe_r, .power_stage_en_r,
        .fault_reset_r, .halt_r, .jog_positive_r, .jog_fast_r,
        .home_switch_r, .positive_travel_stop_r, .digital_out_r,
        .home_position_r, .home_position_load_r, .search_cancel_r);
    drive_switch_model i_drive_switch_model (.sys_clk,
        .pin_oe(local_io_pin1_oe_r), .pin_out(local_io_pin1_out_r),
        .pin_ext, .go, .steps, .pin_in(local_io_pin1_in), .step_pulse);
    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp1(input logic g, input logic e);
        cmp32({31'h0, g}, {31'h0, e});
    endtask
    task automatic conclude;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [15:0] a,
                        input logic [31:0] d);
        @(negedge sys_clk);
        par_addr = a;
        par_wdata = d;
        par_wr = w;
        par_rd = !w;
        @(negedge sys_clk);
        par_wr = 0;
        par_rd = 0;
        cmp1(par_ack_r, 1'b1);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic e);
        xfer(1'b1, a, d);
        cmp1(par_err_r, e);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        cmp32(par_rdata_r, e);
    endtask
    task automatic wait_en(input logic e);
        for (i = 0; i < 10 && power_stage_en_r !== e; i++)
            @(negedge sys_clk);
        cmp1(power_stage_en_r, e);
        if (power_stage_en_r !== e)
            conclude();
    endtask
    task automatic t_regs;
        rd(`ADDR_POWER_ON_ENABLE_POLICY, 32'h0);
        rd(`ADDR_PIN1_FUNCTION_SELECT, 32'h1);
        rd(`ADDR_HOMING_PRESET_POSITION, 32'h0);
        rd(16'h0100, 32'h0);
        wr(16'h0100, 32'h1, 1'b1);
        wr(`ADDR_OVERTRAVEL_SEARCH_LIMIT, 32'h7FFF_FFFF, 1'b0);
        wr(`ADDR_OVERTRAVEL_SEARCH_LIMIT, 32'h8000_0000, 1'b1);
        rd(`ADDR_OVERTRAVEL_SEARCH_LIMIT, 32'h7FFF_FFFF);
        wr(`ADDR_POWER_ON_ENABLE_POLICY, 32'h3, 1'b1);
        wr(`ADDR_PIN1_FUNCTION_SELECT, 32'h5, 1'b1);
        wr(`ADDR_DIRECT_OUTPUT_BITS, 32'h0000_A5C3, 1'b0);
        @(negedge sys_clk);
        cmp32({16'h0, digital_out_r}, 32'h0000_A5C3);
    endtask
    task automatic t_preset;
        wr(`ADDR_HOMING_PRESET_POSITION, 32'h8000_0001, 1'b0);
        @(negedge sys_clk);
        move_start = 1;
        @(negedge sys_clk);
        move_start = 0;
        cmp1(home_position_load_r, 1'b1);
        cmp32(home_position_r, 32'h8000_0001);
        homing_method = 8'h06;
        move_start = 1;
        @(negedge sys_clk);
        move_start = 0;
        homing_method = 8'h23;
        cmp1(home_position_load_r, 1'b0);
    endtask
    task automatic t_search(input logic [31:0] lim, input logic [7:0] n,
                            input logic e);
        wr(`ADDR_OVERTRAVEL_SEARCH_LIMIT, lim, 1'b0);
        @(negedge sys_clk);
        move_start = 1;
        search_active = 1;
        @(negedge sys_clk);
        move_start = 0;
        steps = n;
        go = 1;
        @(negedge sys_clk);
        go = 0;
        for (i = 0; i < 16 && search_cancel_r !== 1'b1; i++)
            @(negedge sys_clk);
        cmp1(search_cancel_r, e);
        search_active = 0;
        if (e && search_cancel_r !== 1'b1)
            conclude();
    endtask
    task automatic t_enable;
        wr(`ADDR_POWER_ON_ENABLE_POLICY, 32'h2, 1'b0);
        wait_en(1'b1);
        wr(`ADDR_POWER_ON_ENABLE_POLICY, 32'h0, 1'b0);
        wait_en(1'b1);
        wr(`ADDR_PIN1_FUNCTION_SELECT, 32'h4, 1'b1);
        rd(`ADDR_PIN1_FUNCTION_SELECT, 32'h1);
        disable_req = 1;
        wait_en(1'b0);
        wr(`ADDR_PIN1_FUNCTION_SELECT, 32'h4, 1'b0);
        rd(`ADDR_PIN1_FUNCTION_SELECT, 32'h4);
        pin_ext = 1;
        disable_req = 0;
        repeat (6) @(negedge sys_clk);
        cmp1(halt_r, 1'b0);
        cmp1(power_stage_en_r, 1'b0);
    endtask
    task automatic reboot(input logic [15:0] c);
        wr(`ADDR_PIN1_FUNCTION_SELECT, {16'h0, c}, 1'b0);
        @(negedge sys_clk) sys_rst = 1;
        @(negedge sys_clk) sys_rst = 0;
        @(negedge sys_clk);
        rd(`ADDR_PIN1_FUNCTION_SELECT, {16'h0, c});
    endtask
    task automatic t_pin_in;
        pin_ext = 0;
        reboot(`FN_IN_HALT);
        pin_ext = 1;
        @(negedge sys_clk);
        cmp1(halt_r, 1'b1);
        cmp1(local_io_pin1_oe_r, 1'b0);
        pin_ext = 0;
        reboot(`FN_IN_JOG_POS);
        pin_ext = 1;
        @(negedge sys_clk);
        cmp1(jog_positive_r, 1'b1);
        cmp1(halt_r, 1'b0);
        pin_ext = 0;
        reboot(`FN_IN_JOG_FAST);
        pin_ext = 1;
        @(negedge sys_clk);
        cmp1(jog_fast_r, 1'b1);
        pin_ext = 0;
        reboot(`FN_IN_HOME_SWITCH);
        pin_ext = 1;
        @(negedge sys_clk);
        cmp1(home_switch_r, 1'b1);
        pin_ext = 0;
        reboot(`FN_IN_POS_TRAVEL_STOP);
        pin_ext = 1;
        @(negedge sys_clk);
        cmp1(positive_travel_stop_r, 1'b1);
        pin_ext = 0;
        reboot(`FN_IN_FAULT_RESET);
        pin_ext = 1;
        @(negedge sys_clk);
        cmp1(fault_reset_r, 1'b1);
        local_mode = 0;
        @(negedge sys_clk);
        cmp1(fault_reset_r, 1'b0);
        local_mode = 1;
        pin_ext = 0;
    endtask
    task automatic t_pin_enable;
        reboot(`FN_IN_ENABLE);
        repeat (3) @(negedge sys_clk);
        cmp1(power_stage_en_r, 1'b0);
        pin_ext = 1;
        wait_en(1'b1);
        pin_ext = 0;
        wr(`ADDR_POWER_ON_ENABLE_POLICY, 32'h1, 1'b0);
        cmp1(power_stage_en_r, 1'b1);
        disable_req = 1;
        wait_en(1'b0);
        disable_req = 0;
        pin_ext = 1;
        wait_en(1'b1);
        pin_ext = 0;
        wait_en(1'b0);
        local_mode = 0;
        pin_ext = 1;
        repeat (3) @(negedge sys_clk);
        cmp1(power_stage_en_r, 1'b0);
        local_mode = 1;
        pin_ext = 0;
    endtask
    task automatic t_pin_out;
        reboot(`FN_OUT_READY);
        drive_ready = 1;
        @(negedge sys_clk);
        cmp1(local_io_pin1_oe_r, 1'b1);
        cmp1(local_io_pin1_out_r, 1'b1);
        drive_ready = 0;
        @(negedge sys_clk);
        cmp1(local_io_pin1_out_r, 1'b0);
        reboot(`FN_OUT_NO_FAULT);
        drive_fault = 1;
        @(negedge sys_clk);
        cmp1(local_io_pin1_out_r, 1'b0);
        drive_fault = 0;
        @(negedge sys_clk);
        cmp1(local_io_pin1_out_r, 1'b1);
        reboot(`FN_OUT_FREE);
        wr(`ADDR_DIRECT_OUTPUT_BITS, 32'h1, 1'b0);
        @(negedge sys_clk);
        cmp1(local_io_pin1_out_r, 1'b1);
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk) sys_rst = 0;
        @(negedge sys_clk);
        t_regs();
        t_preset();
        t_search(32'h3, 8'h02, 1'b0);
        t_search(32'h3, 8'h03, 1'b1);
        t_search(32'h0, 8'h08, 1'b0);
        t_enable();
        t_pin_in();
        t_pin_enable();
        t_pin_out();
        conclude();
    end
endmodule
`default_nettype wire
